// [design/fsc_pkg.sv]
// shared constants of the fuse and signature configuration store
// assumes a 32-bit classic wishbone bus with byte addresses
package fsc_pkg;

    // ************************************************************
    // register map (byte addresses, one word each)
    // ************************************************************
    localparam int ADR_W = 6;
    localparam logic [5:0] OFF_FUSE_EXT = 6'h00;
    localparam logic [5:0] OFF_FUSE_HIGH = 6'h04;
    localparam logic [5:0] OFF_FUSE_LOW = 6'h08;
    localparam logic [5:0] OFF_LOCK = 6'h0C;
    localparam logic [5:0] OFF_CTRL = 6'h10;
    localparam logic [5:0] OFF_STATUS = 6'h14;
    localparam logic [5:0] OFF_LATCH = 6'h18;
    localparam logic [5:0] OFF_SIG0 = 6'h20;
    localparam logic [5:0] OFF_SIG1 = 6'h24;
    localparam logic [5:0] OFF_SIG2 = 6'h28;
    localparam logic [5:0] OFF_CAL = 6'h2C;
    localparam logic [5:0] OFF_TRIM = 6'h30;

    // ************************************************************
    // fuse defaults, 0 = programmed
    // ************************************************************
    localparam logic [7:0] EXT_DEF_BOOT = 8'hF9;
    localparam logic [7:0] EXT_DEF_NOBOOT = 8'hFF;
    localparam logic [7:0] EXT_USED_BOOT = 8'h07;
    localparam logic [7:0] EXT_USED_NOBOOT = 8'h01;
    localparam logic [7:0] HIGH_DEF = 8'hDF;
    localparam logic [7:0] LOW_DEF = 8'h62;
    localparam logic [7:0] LOCK_DEF = 8'hFF;
    localparam logic [7:0] BYTE_ONES = 8'hFF;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int EXT_SELF_PROG = 0;
    localparam int EXT_RST_VEC = 0;
    localparam int EXT_BOOT_LO = 1;
    localparam int EXT_BOOT_HI = 2;
    localparam int HI_BOD_LO = 0;
    localparam int HI_BOD_HI = 2;
    localparam int HI_KEEP = 3;
    localparam int HI_WDT = 4;
    localparam int HI_SERIAL = 5;
    localparam int HI_DEBUG = 6;
    localparam int HI_RST_OFF = 7;
    localparam int LO_CKSEL_LO = 0;
    localparam int LO_CKSEL_HI = 3;
    localparam int LO_SUT_LO = 4;
    localparam int LO_SUT_HI = 5;
    localparam int LO_CLOCK_OUT_FUSE = 6;
    localparam int LO_DIV8 = 7;
    localparam int LOCK_FIRST = 0;
    localparam int CTRL_PROG = 0;
    localparam int CTRL_SERIAL = 1;
    localparam int CTRL_ERASE = 2;
    localparam int ST_PROG = 0;
    localparam int ST_REJECT = 1;
    localparam int ST_KEEP = 2;

    // ************************************************************
    // signature defaults (identity values arbitrary)
    // ************************************************************
    localparam logic [7:0] SIG0_DEF = 8'h5A;
    localparam logic [7:0] SIG1_DEF = 8'hC3;
    localparam logic [7:0] SIG2_DEF = 8'h21;
    localparam logic [7:0] CAL_DEF = 8'h80;

    typedef enum logic [2:0] {
        FSC_LOAD = 3'b001,
        FSC_RUN = 3'b010,
        FSC_PROG = 3'b100
    } fsc_state_t;

endpackage

// [design/fsc_store.sv]
// fuse image, lock byte, signature space and oscillator trim
// assumes one 125 MHz clock and a classic wishbone master
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
module fsc_store #(
    parameter int HAS_BOOT = 1,
    parameter logic [7:0] SIG0 = fsc_pkg::SIG0_DEF,
    parameter logic [7:0] SIG1 = fsc_pkg::SIG1_DEF,
    parameter logic [7:0] SIG2 = fsc_pkg::SIG2_DEF,
    parameter logic [7:0] CAL_BYTE = fsc_pkg::CAL_DEF
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [3:0] clock_source_o,
    output logic [1:0] startup_delay_o,
    output logic clock_out_fuse_o,
    output logic clock_div_eight_fuse_o,
    output logic [2:0] brownout_level_o,
    output logic watchdog_force_fuse_o,
    output logic eeprom_keep_fuse_o,
    output logic serial_prog_fuse_o,
    output logic onewire_debug_fuse_o,
    output logic ext_reset_off_fuse_o,
    output logic [1:0] boot_area_size_o,
    output logic reset_vector_select_o,
    output logic eeprom_keep_o,
    output logic prog_mode_o,
    output logic [7:0] osc_trim_register_o,
    output logic erase_flash_o,
    output logic erase_eeprom_o
);

    // ************************************************************
    // parameter checks and derived constants
    // ************************************************************
    if (HAS_BOOT != 0 && HAS_BOOT != 1) begin : g_chk
        $error("HAS_BOOT must be 0 or 1");
    end

    localparam logic [7:0] EXT_DEF = (HAS_BOOT == 1) ?
        fsc_pkg::EXT_DEF_BOOT : fsc_pkg::EXT_DEF_NOBOOT;
    localparam logic [7:0] EXT_USED = (HAS_BOOT == 1) ?
        fsc_pkg::EXT_USED_BOOT : fsc_pkg::EXT_USED_NOBOOT;

    function automatic logic [31:0] widen(input logic [7:0] b);
        widen = {24'h000000, b};
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    fsc_pkg::fsc_state_t state_r, state_nxt;
    logic [7:0] img_ext_r, img_ext_nxt;
    logic [7:0] img_high_r, img_high_nxt;
    logic [7:0] img_low_r, img_low_nxt;
    logic [7:0] lat_ext_r, lat_ext_nxt;
    logic [7:0] lat_high_r, lat_high_nxt;
    logic [7:0] lat_low_r, lat_low_nxt;
    logic [7:0] lock_r, lock_nxt;
    logic [1:0] ctrl_r, ctrl_nxt;
    logic reject_r, reject_nxt;
    logic keep_r, keep_nxt;
    logic [7:0] trim_r, trim_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic erase_fl_r, erase_fl_nxt;
    logic erase_ee_r, erase_ee_nxt;

    logic req;
    logic wr;
    logic in_prog;
    logic fuse_ok;
    logic keep_now;
    logic erase_cmd;
    logic [7:0] wbyte;

    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign in_prog = (state_r == fsc_pkg::FSC_PROG);
    // fuse writes only in programming mode and while unlocked
    assign fuse_ok = in_prog & lock_r[fsc_pkg::LOCK_FIRST];
    // keep fuse acts at once, no wait for the next latch
    assign keep_now = ~lat_high_r[fsc_pkg::HI_KEEP] |
        (in_prog & ~img_high_r[fsc_pkg::HI_KEEP]);
    assign erase_cmd = wr & in_prog & (wb_adr_i == fsc_pkg::OFF_CTRL) &
        wbyte[fsc_pkg::CTRL_ERASE];

    // ************************************************************
    // mode sequencing and latching
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        lat_ext_nxt = lat_ext_r;
        lat_high_nxt = lat_high_r;
        lat_low_nxt = lat_low_r;
        case (state_r)
            fsc_pkg::FSC_LOAD: begin
                // power-up or programming exit: capture image
                lat_ext_nxt = img_ext_r;
                lat_high_nxt = img_high_r;
                lat_low_nxt = img_low_r;
                state_nxt = fsc_pkg::FSC_RUN;
            end
            fsc_pkg::FSC_RUN: begin
                if (ctrl_r[fsc_pkg::CTRL_PROG]) begin
                    lat_ext_nxt = img_ext_r;
                    lat_high_nxt = img_high_r;
                    lat_low_nxt = img_low_r;
                    state_nxt = fsc_pkg::FSC_PROG;
                end
            end
            fsc_pkg::FSC_PROG: begin
                // latched image frozen until exit
                if (!ctrl_r[fsc_pkg::CTRL_PROG]) begin
                    state_nxt = fsc_pkg::FSC_LOAD;
                end
            end
            default: begin
                state_nxt = fsc_pkg::FSC_LOAD;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= fsc_pkg::FSC_LOAD;
            lat_ext_r <= EXT_DEF;
            lat_high_r <= fsc_pkg::HIGH_DEF;
            lat_low_r <= fsc_pkg::LOW_DEF;
        end else if (ce_i) begin
            state_r <= state_nxt;
            lat_ext_r <= lat_ext_nxt;
            lat_high_r <= lat_high_nxt;
            lat_low_r <= lat_low_nxt;
        end
    end

    // ************************************************************
    // fuse image, lock byte, control and trim writes
    // ************************************************************
    always_comb begin
        img_ext_nxt = img_ext_r;
        img_high_nxt = img_high_r;
        img_low_nxt = img_low_r;
        lock_nxt = lock_r;
        ctrl_nxt = ctrl_r;
        reject_nxt = reject_r;
        trim_nxt = trim_r;
        erase_fl_nxt = 1'b0;
        erase_ee_nxt = 1'b0;
        keep_nxt = keep_now;
        if (wr) begin
            case (wb_adr_i)
                fsc_pkg::OFF_FUSE_EXT: begin
                    if (fuse_ok) begin
                        img_ext_nxt = wbyte | ~EXT_USED;
                    end
                end
                fsc_pkg::OFF_FUSE_HIGH: begin
                    if (fuse_ok) begin
                        img_high_nxt = wbyte;
                        if (ctrl_r[fsc_pkg::CTRL_SERIAL]) begin
                            img_high_nxt[fsc_pkg::HI_SERIAL] =
                                img_high_r[fsc_pkg::HI_SERIAL];
                        end
                    end
                end
                fsc_pkg::OFF_FUSE_LOW: begin
                    if (fuse_ok) begin
                        img_low_nxt = wbyte;
                    end
                end
                fsc_pkg::OFF_LOCK: begin
                    // lock bits can only be programmed by writes; erase restores them
                    if (in_prog) begin
                        lock_nxt = lock_r & wbyte;
                    end
                end
                fsc_pkg::OFF_CTRL: begin
                    ctrl_nxt[fsc_pkg::CTRL_PROG] = wbyte[fsc_pkg::CTRL_PROG];
                    ctrl_nxt[fsc_pkg::CTRL_SERIAL] =
                        wbyte[fsc_pkg::CTRL_SERIAL];
                end
                fsc_pkg::OFF_STATUS: begin
                    if (wbyte[fsc_pkg::ST_REJECT]) begin
                        reject_nxt = 1'b0;
                    end
                end
                fsc_pkg::OFF_TRIM: begin
                    trim_nxt = wbyte;
                end
                default: begin
                end
            endcase
        end
        // rejection set wins over a same-cycle clear
        if (wr && !fuse_ok && (wb_adr_i == fsc_pkg::OFF_FUSE_EXT ||
                wb_adr_i == fsc_pkg::OFF_FUSE_HIGH ||
                wb_adr_i == fsc_pkg::OFF_FUSE_LOW)) begin
            reject_nxt = 1'b1;
        end
        if (erase_cmd) begin
            // fuse image left untouched by erase
            lock_nxt = fsc_pkg::LOCK_DEF;
            erase_fl_nxt = 1'b1;
            erase_ee_nxt = ~keep_now;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            img_ext_r <= EXT_DEF;
            img_high_r <= fsc_pkg::HIGH_DEF;
            img_low_r <= fsc_pkg::LOW_DEF;
            lock_r <= fsc_pkg::LOCK_DEF;
            ctrl_r <= 2'h0;
            reject_r <= 1'b0;
            keep_r <= 1'b0;
            trim_r <= CAL_BYTE;
            erase_fl_r <= 1'b0;
            erase_ee_r <= 1'b0;
        end else if (ce_i) begin
            img_ext_r <= img_ext_nxt;
            img_high_r <= img_high_nxt;
            img_low_r <= img_low_nxt;
            lock_r <= lock_nxt;
            ctrl_r <= ctrl_nxt;
            reject_r <= reject_nxt;
            keep_r <= keep_nxt;
            trim_r <= trim_nxt;
            erase_fl_r <= erase_fl_nxt;
            erase_ee_r <= erase_ee_nxt;
        end
    end

    // ************************************************************
    // wishbone read path
    // ************************************************************
    always_comb begin
        ack_nxt = req;
        rdat_nxt = 32'h00000000;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                fsc_pkg::OFF_FUSE_EXT: rdat_nxt = widen(img_ext_r);
                fsc_pkg::OFF_FUSE_HIGH: rdat_nxt = widen(img_high_r);
                fsc_pkg::OFF_FUSE_LOW: rdat_nxt = widen(img_low_r);
                fsc_pkg::OFF_LOCK: rdat_nxt = widen(lock_r);
                fsc_pkg::OFF_CTRL: rdat_nxt = {30'h0, ctrl_r};
                fsc_pkg::OFF_STATUS: rdat_nxt = {29'h0, keep_r, reject_r, in_prog};
                fsc_pkg::OFF_LATCH: begin
                    rdat_nxt = {8'h00, lat_ext_r, lat_high_r, lat_low_r};
                end
                // signature space ignores lock bits
                fsc_pkg::OFF_SIG0: rdat_nxt = widen(SIG0);
                fsc_pkg::OFF_SIG1: rdat_nxt = widen(SIG1);
                fsc_pkg::OFF_SIG2: rdat_nxt = widen(SIG2);
                fsc_pkg::OFF_CAL: rdat_nxt = widen(CAL_BYTE);
                fsc_pkg::OFF_TRIM: rdat_nxt = widen(trim_r);
                default: rdat_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h00000000;
        end else if (ce_i) begin
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // ************************************************************
    // outputs, all from the latched image or flops
    // ************************************************************
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign clock_source_o =
        lat_low_r[fsc_pkg::LO_CKSEL_HI:fsc_pkg::LO_CKSEL_LO];
    assign startup_delay_o =
        lat_low_r[fsc_pkg::LO_SUT_HI:fsc_pkg::LO_SUT_LO];
    assign clock_out_fuse_o = lat_low_r[fsc_pkg::LO_CLOCK_OUT_FUSE];
    assign clock_div_eight_fuse_o = lat_low_r[fsc_pkg::LO_DIV8];
    assign brownout_level_o =
        lat_high_r[fsc_pkg::HI_BOD_HI:fsc_pkg::HI_BOD_LO];
    assign watchdog_force_fuse_o = lat_high_r[fsc_pkg::HI_WDT];
    assign eeprom_keep_fuse_o = lat_high_r[fsc_pkg::HI_KEEP];
    assign serial_prog_fuse_o = lat_high_r[fsc_pkg::HI_SERIAL];
    assign onewire_debug_fuse_o = lat_high_r[fsc_pkg::HI_DEBUG];
    assign ext_reset_off_fuse_o = lat_high_r[fsc_pkg::HI_RST_OFF];
    assign boot_area_size_o =
        lat_ext_r[fsc_pkg::EXT_BOOT_HI:fsc_pkg::EXT_BOOT_LO];
    assign reset_vector_select_o = lat_ext_r[fsc_pkg::EXT_RST_VEC];
    assign eeprom_keep_o = keep_r;
    assign prog_mode_o = state_r[2];
    assign osc_trim_register_o = trim_r;
    assign erase_flash_o = erase_fl_r;
    assign erase_eeprom_o = erase_ee_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    a_lock_blocks_fuse: assert property (
        (ce_i && wr && !lock_r[fsc_pkg::LOCK_FIRST] &&
            wb_adr_i < fsc_pkg::OFF_LOCK && wb_adr_i[1:0] == 2'h0) |=>
            $stable(img_ext_r) && $stable(img_high_r) &&
            $stable(img_low_r) && reject_r)
        else $error("fuse changed while locked");

    a_serial_keeps_bit: assert property (
        (ce_i && wr && ctrl_r[fsc_pkg::CTRL_SERIAL] &&
            wb_adr_i == fsc_pkg::OFF_FUSE_HIGH) |=>
            img_high_r[fsc_pkg::HI_SERIAL] ==
                $past(img_high_r[fsc_pkg::HI_SERIAL]))
        else $error("serial write changed serial enable fuse");

    a_erase_keeps_fuse: assert property (
        (ce_i && erase_cmd) |=> $stable(img_ext_r) &&
            $stable(img_high_r) && $stable(img_low_r) &&
            lock_r == fsc_pkg::LOCK_DEF && erase_flash_o)
        else $error("chip erase disturbed fuses");

    a_keep_guard_ee: assert property (
        (ce_i && erase_cmd && keep_now) |=> !erase_eeprom_o)
        else $error("eeprom erased while keep fuse active");

    a_prog_entry_lat: assert property (
        (ce_i && state_r == fsc_pkg::FSC_RUN &&
            ctrl_r[fsc_pkg::CTRL_PROG]) |=>
            prog_mode_o && lat_high_r == $past(img_high_r) &&
            lat_low_r == $past(img_low_r))
        else $error("fuses not captured on programming entry");

    a_prog_lat_frozen: assert property (
        (in_prog && $past(in_prog)) |-> $stable(lat_low_r) &&
            $stable(lat_high_r) && $stable(lat_ext_r))
        else $error("latched fuses moved in programming mode");

    a_powerup_latch: assert property (
        (ce_i && state_r == fsc_pkg::FSC_LOAD) |=>
            state_r == fsc_pkg::FSC_RUN &&
            lat_low_r == $past(img_low_r))
        else $error("fuses not captured at power-up");

    a_keep_immediate: assert property (
        (ce_i && in_prog && ctrl_r[fsc_pkg::CTRL_PROG] &&
            !img_high_r[fsc_pkg::HI_KEEP]) |=> eeprom_keep_o)
        else $error("keep fuse not effective at once");

    a_sig_any_lock: assert property (
        (ce_i && req && !wb_we_i && wb_adr_i == fsc_pkg::OFF_SIG0) |=>
            wb_ack_o && wb_dat_o == widen(SIG0))
        else $error("identity byte read wrong");

    a_trim_after_rst: assert property (
        !$past(rst_n_i) |-> osc_trim_register_o == CAL_BYTE)
        else $error("trim not loaded from calibration byte");

    a_ack_single: assert property (
        (wb_ack_o && ce_i) |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    c_fuse_write: cover property (
        ce_i && wr && fuse_ok && wb_adr_i == fsc_pkg::OFF_FUSE_LOW);
    c_erase_keep: cover property (ce_i && erase_cmd && keep_now);
    c_rejected: cover property (ce_i && wr && !fuse_ok &&
        wb_adr_i == fsc_pkg::OFF_FUSE_HIGH);
    c_prog_exit: cover property (in_prog ##1 !in_prog);

endmodule

// [test/fsc_prog_model.sv]
// programmer model: classic wishbone master of the fuse store
// assumes one clock and a registered ack from the store
`timescale 1ns/1ns
module fsc_prog_model (
    input wire logic clock_i,
    input wire logic wb_ack_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [5:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o
);
    int to_cnt;

    initial begin
        to_cnt = 0;
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 6'h3F;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end

    // ************************************************************
    // one bus cycle, held until ack is sampled or 64 clocks pass
    // ************************************************************
    task automatic xfer(input logic we, input logic [5:0] adr,
                        input logic [3:0] sel, input logic [31:0] dat);
        int n;
        @(posedge clock_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_sel_o <= sel;
        wb_dat_o <= dat;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (wb_ack_i !== 1'b1 && n < 64);
        if (wb_ack_i !== 1'b1) to_cnt++;
        // released lines show the inverse, not the last value
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= ~we;
        wb_adr_o <= ~adr;
        wb_sel_o <= ~sel;
        wb_dat_o <= ~dat;
    endtask
endmodule

// [test/tb_fsc_store.sv]
// self-checking bench of the fuse and signature store
// assumes the programmer model drives the register bus
`timescale 1ns/1ns
module tb_fsc_store;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic wb_cyc, wb_stb, wb_we, wb_ack, clock_out_fuse, div8, wdt, keep_f, ser_f;
    logic dbg_f, rst_off, vec, keep, prog, er_fl, er_ee;
    logic [5:0] wb_adr;
    logic [3:0] wb_sel, clk_src;
    logic [31:0] wb_wdat, wb_rdat;
    logic [1:0] sut, boot;
    logic [2:0] bod;
    logic [7:0] trim, r, t;
    logic [31:0] exp_q[$];
    int error_cnt = 0;
    int compares = 0;
    int flash_cnt = 0;
    int ee_cnt = 0;

    always #4 clock_i = ~clock_i;

    fsc_prog_model fsc_prog_model_inst (.clock_i(clock_i), .wb_ack_i(wb_ack),
        .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
        .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat));

    fsc_store fsc_store_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .ce_i(ce_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .clock_source_o(clk_src),
        .startup_delay_o(sut), .clock_out_fuse_o(clock_out_fuse),
        .clock_div_eight_fuse_o(div8), .brownout_level_o(bod),
        .watchdog_force_fuse_o(wdt), .eeprom_keep_fuse_o(keep_f),
        .serial_prog_fuse_o(ser_f), .onewire_debug_fuse_o(dbg_f),
        .ext_reset_off_fuse_o(rst_off), .boot_area_size_o(boot),
        .reset_vector_select_o(vec), .eeprom_keep_o(keep),
        .prog_mode_o(prog), .osc_trim_register_o(trim),
        .erase_flash_o(er_fl), .erase_eeprom_o(er_ee));

    // ************************************************************
    // compare, bus and closing tasks
    // ************************************************************
    task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected read data exp %h got %h", e, g);
        end
    endtask

    task automatic chk_sig(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic summarize();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic bus(input logic we, input logic [5:0] a,
                       input logic [3:0] s, input logic [31:0] d);
        fsc_prog_model_inst.xfer(we, a, s, d);
        if (fsc_prog_model_inst.to_cnt != 0) begin
            error_cnt++;
            summarize();
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, 4'hF, {24'h0, d});
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 4'hF, 32'h0);
    endtask

    function automatic logic [7:0] lo_o();
        return {div8, clock_out_fuse, sut, clk_src};
    endfunction

    function automatic logic [7:0] hi_o();
        return {rst_off, dbg_f, ser_f, wdt, keep_f, bod};
    endfunction

    // ************************************************************
    // read monitor and erase pulse counters
    // ************************************************************
    always @(posedge clock_i) begin
        if (wb_cyc === 1'b1 && wb_ack === 1'b1 && wb_we === 1'b0) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("unexpected read data with no note");
            end else chk_rd(exp_q.pop_front(), wb_rdat);
        end
        if (er_fl === 1'b1) flash_cnt++;
        if (er_ee === 1'b1) ee_cnt++;
    end

    initial begin
        #500000;
        error_cnt++;
        summarize();
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        void'($urandom(1899));
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        #1;
        chk_sig("low outputs", 8'h62, lo_o());
        chk_sig("high outputs", 8'hDF, hi_o());
        chk_sig("ext outputs", 8'h01, {5'h0, boot, vec});
        chk_sig("trim", 8'h80, trim);
        rd(fsc_pkg::OFF_FUSE_EXT, 32'hF9);
        rd(fsc_pkg::OFF_FUSE_HIGH, 32'hDF);
        rd(fsc_pkg::OFF_FUSE_LOW, 32'h62);
        rd(fsc_pkg::OFF_SIG0, {24'h0, fsc_pkg::SIG0_DEF});
        rd(fsc_pkg::OFF_SIG1, {24'h0, fsc_pkg::SIG1_DEF});
        // clock enable low stalls the store and delays the read ack
        fork
            rd(fsc_pkg::OFF_SIG2, {24'h0, fsc_pkg::SIG2_DEF});
            begin
                ce_i <= 1'b0;
                repeat (3) @(posedge clock_i);
                ce_i <= 1'b1;
            end
        join
        rd(fsc_pkg::OFF_CAL, 32'h80);
        rd(6'h3C, 32'h0);
        wr(fsc_pkg::OFF_FUSE_LOW, 8'h00);
        rd(fsc_pkg::OFF_FUSE_LOW, 32'h62);
        rd(fsc_pkg::OFF_STATUS, 32'h2);
        wr(fsc_pkg::OFF_STATUS, 8'h02);
        rd(fsc_pkg::OFF_STATUS, 32'h0);
        wr(fsc_pkg::OFF_CTRL, 8'h01);
        rd(fsc_pkg::OFF_STATUS, 32'h1);
        r = 8'($urandom);
        wr(fsc_pkg::OFF_FUSE_LOW, r);
        rd(fsc_pkg::OFF_FUSE_LOW, {24'h0, r});
        bus(1'b1, fsc_pkg::OFF_FUSE_LOW, 4'hE, {24'h0, ~r});
        rd(fsc_pkg::OFF_FUSE_LOW, {24'h0, r});
        wr(fsc_pkg::OFF_FUSE_EXT, 8'h00);
        rd(fsc_pkg::OFF_FUSE_EXT, 32'hF8);
        // erase with keep fuse unprogrammed clears eeprom too
        wr(fsc_pkg::OFF_CTRL, 8'h05);
        wr(fsc_pkg::OFF_FUSE_HIGH, 8'hD7);
        #1;
        chk_sig("keep now", 8'h1, {7'h0, keep});
        chk_sig("low held", 8'h62, lo_o());
        chk_sig("keep fuse held", 8'h1, {7'h0, keep_f});
        chk_sig("prog mode", 8'h1, {7'h0, prog});
        wr(fsc_pkg::OFF_CTRL, 8'h05);
        repeat (2) @(posedge clock_i);
        chk_sig("flash erases", 8'h2, 8'(flash_cnt));
        chk_sig("eeprom erases", 8'h1, 8'(ee_cnt));
        rd(fsc_pkg::OFF_FUSE_HIGH, 32'hD7);
        rd(fsc_pkg::OFF_FUSE_LOW, {24'h0, r});
        wr(fsc_pkg::OFF_CTRL, 8'h03);
        wr(fsc_pkg::OFF_FUSE_HIGH, 8'hF7);
        rd(fsc_pkg::OFF_FUSE_HIGH, 32'hD7);
        wr(fsc_pkg::OFF_CTRL, 8'h01);
        wr(fsc_pkg::OFF_LOCK, 8'hFE);
        wr(fsc_pkg::OFF_FUSE_LOW, 8'hFF);
        rd(fsc_pkg::OFF_FUSE_LOW, {24'h0, r});
        rd(fsc_pkg::OFF_STATUS, 32'h7);
        rd(fsc_pkg::OFF_SIG0, {24'h0, fsc_pkg::SIG0_DEF});
        wr(fsc_pkg::OFF_CTRL, 8'h00);
        repeat (2) @(posedge clock_i);
        #1;
        chk_sig("low relatched", r, lo_o());
        chk_sig("high relatched", 8'hD7, hi_o());
        chk_sig("ext relatched", 8'h0, {5'h0, boot, vec});
        chk_sig("prog after exit", 8'h0, {7'h0, prog});
        rd(fsc_pkg::OFF_LATCH, {8'h0, 8'hF8, 8'hD7, r});
        t = 8'($urandom);
        wr(fsc_pkg::OFF_TRIM, t);
        rd(fsc_pkg::OFF_TRIM, {24'h0, t});
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        chk_sig("trim after reset", 8'h80, trim);
        chk_sig("low after reset", 8'h62, lo_o());
        for (int i = 0; i < 16 && exp_q.size() != 0; i++) @(posedge clock_i);
        if (exp_q.size() != 0) error_cnt++;
        summarize();
    end
endmodule
